// File: design/ued_pkg.sv
/*
 * Package for the device endpoint support block: register indices, field
 * positions, reset values, token and reply codes.
 * Assumes a 32-bit APB register port and the controller system clock.
 */
package ued_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] UED_IDX_REPLY_POINTER = 12'h120;
    localparam logic [11:0] UED_IDX_REPLY_LENGTH  = 12'h122;
    localparam logic [11:0] UED_IDX_DMA_FIFO_CTRL = 12'h126;
    localparam logic [11:0] UED_IDX_IN_ENABLES    = 12'h128;
    localparam logic [11:0] UED_IDX_OUT_ENABLES   = 12'h12a;
    localparam logic [11:0] UED_IDX_SHORT_CTRL    = 12'h130;

    // Field widths and positions
    localparam int          UED_LEN_W          = 10;
    localparam int          UED_PTR_W          = 13;
    localparam int          UED_EP_NUM         = 16;
    localparam int          UED_FIFO_RUN_BIT   = 7;
    localparam int          UED_AUTO_SHORT_BIT = 6;
    localparam int          UED_SHORT_ARM_BIT  = 0;

    // Reset values and enable write mask
    localparam logic [UED_LEN_W-1:0]  UED_LEN_RESET  = 10'h000;
    localparam logic [UED_PTR_W-1:0]  UED_PTR_RESET  = 13'h0000;
    localparam logic [UED_EP_NUM-1:0] UED_EN_RESET   = 16'h0000;
    localparam logic [UED_EP_NUM-1:0] UED_EN_WMASK   = 16'hfffe;

    // Host token kinds, one-hot
    typedef enum logic [2:0] {
        UED_TOK_IN   = 3'b001,
        UED_TOK_OUT  = 3'b010,
        UED_TOK_PING = 3'b100
    } ued_token_type;

    // Default reply kinds, one-hot
    typedef enum logic [3:0] {
        UED_REP_NONE = 4'b0001,
        UED_REP_NAK  = 4'b0010,
        UED_REP_ZLP  = 4'b0100,
        UED_REP_DROP = 4'b1000
    } ued_reply_type;

endpackage : ued_pkg

// File: design/ued_token_reply.sv
/*
 * Default token responder for enabled endpoints that have no configured,
 * joined FIFO slot.
 * Assumes token strobes arrive from the serial engine on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ued_token_reply
    import ued_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_token_valid,
    input  wire ued_token_type         i_token_kind,
    input  wire logic [3:0]            i_token_ep,
    input  wire logic                  i_high_speed,
    input  wire logic [UED_EP_NUM-1:0] i_in_enable,
    input  wire logic [UED_EP_NUM-1:0] i_out_enable,
    input  wire logic [UED_EP_NUM-1:0] i_in_iso_null_reply,
    input  wire logic [UED_EP_NUM-1:0] i_out_iso_silent_drop,
    input  wire logic [UED_EP_NUM-1:0] i_endpoint_area_link,
    output logic                       o_reply_valid,
    output ued_reply_type              o_reply_kind
);

    logic          handled;
    ued_reply_type kind_d;

    // Endpoint qualifies when enabled and not configured-and-joined
    always_comb begin
        handled = !i_endpoint_area_link[i_token_ep];
        kind_d  = UED_REP_NONE;
        unique case (i_token_kind)
            UED_TOK_IN: begin
                if (handled && i_in_enable[i_token_ep]) begin
                    kind_d = i_in_iso_null_reply[i_token_ep] ? UED_REP_ZLP
                                                             : UED_REP_NAK;
                end
            end
            UED_TOK_OUT: begin
                if (handled && i_out_enable[i_token_ep]) begin
                    kind_d = i_out_iso_silent_drop[i_token_ep] ? UED_REP_DROP
                                                               : UED_REP_NAK;
                end
            end
            UED_TOK_PING: begin
                if (handled && i_out_enable[i_token_ep] && i_high_speed) begin
                    kind_d = UED_REP_NAK;
                end
            end
            default: kind_d = UED_REP_NONE;
        endcase
    end

    // Registered one-cycle reply decision
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_reply_valid <= 1'b0;
            o_reply_kind  <= UED_REP_NONE;
        end else begin
            o_reply_valid <= i_token_valid && (kind_d != UED_REP_NONE);
            o_reply_kind  <= i_token_valid ? kind_d : UED_REP_NONE;
        end
    end

endmodule : ued_token_reply

`default_nettype wire

// File: design/ued_endpoint_support.sv
/*
 * Device endpoint support: descriptor reply countdown, DMA FIFO activity
 * and auto short-packet arming, IN/OUT endpoint enable masks and the
 * default token responder, all behind an APB register port.
 * Assumes the serial engine, DMA and FIFO logic share i_clk and give
 * one-cycle event strobes; endpoint control and area join state lives
 * outside and arrives as plain inputs.
 */
// How it works
// - A 10-bit reply length holds the total descriptor byte count, any value 0x000 to 0x3ff.
// - Each finished endpoint 0 IN transaction during a reply subtracts the bytes just sent.
// - The read-only FIFO running flag sets at DMA start and clears once FIFO is empty after DMA end.
// - With auto arm on, a DMA end leaving less than one max packet arms the short packet.
// - Auto arming happens only when the DMA endpoint is an IN endpoint.
// - A 16-bit IN enable mask, bits 1 to 15 read/write, bit 0 reserved, resets to zero.
// - A 16-bit OUT enable mask, bits 1 to 15 read/write, bit 0 reserved, resets to zero.
// - Default replies serve only enabled endpoints that are not configured and joined.
// - An IN token there gets a zero-length packet if iso IN is set, else NAK.
// - An OUT token there has its data dropped silently if iso OUT is set, else NAK.
// - At high speed a PING token to such an OUT endpoint gets NAK.
// - An armed short packet lets the next IN send a short packet, then disarms itself.
// - The reply read pointer advances by the bytes sent, in step with the countdown.
`timescale 1ns/1ps
`default_nettype none

module ued_endpoint_support
    import ued_pkg::*;
#(
    parameter int FIFO_CNT_W = 13,
    parameter int MPS_W      = 11
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    // APB register port
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [13:0]           i_paddr,
    input  wire logic [31:0]           i_pwdata,
    output logic [31:0]                o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    // Descriptor reply events
    input  wire logic                  i_reply_active,
    input  wire logic                  i_ep0_in_done,
    input  wire logic [UED_LEN_W-1:0]  i_ep0_in_bytes,
    output logic [UED_LEN_W-1:0]       o_reply_length_count,
    output logic [UED_PTR_W-1:0]       o_reply_start_pointer,
    // DMA and FIFO status
    input  wire logic                  i_dma_start,
    input  wire logic                  i_dma_end,
    input  wire logic                  i_dma_ep_is_in,
    input  wire logic                  i_fifo_empty,
    input  wire logic [FIFO_CNT_W-1:0] i_fifo_count,
    input  wire logic [MPS_W-1:0]      i_max_packet,
    input  wire logic                  i_in_done,
    input  wire logic                  i_in_short_sent,
    output logic                       o_fifo_running,
    output logic                       o_short_packet_arm,
    // Host tokens and default replies
    input  wire logic                  i_token_valid,
    input  wire ued_token_type         i_token_kind,
    input  wire logic [3:0]            i_token_ep,
    input  wire logic                  i_high_speed,
    input  wire logic [UED_EP_NUM-1:0] i_in_iso_null_reply,
    input  wire logic [UED_EP_NUM-1:0] i_out_iso_silent_drop,
    input  wire logic [UED_EP_NUM-1:0] i_endpoint_area_link,
    output logic                       o_reply_valid,
    output ued_reply_type              o_reply_kind
);

    // Register state
    logic [UED_LEN_W-1:0]  reply_length_q;
    logic [UED_PTR_W-1:0]  reply_pointer_q;
    logic                  fifo_running_q;
    logic                  dma_ended_q;
    logic                  auto_short_arm_q;
    logic                  short_packet_arm_q;
    logic [UED_EP_NUM-1:0] in_enable_q;
    logic [UED_EP_NUM-1:0] out_enable_q;
    logic [31:0]           rdata_q;
    logic                  slverr_q;

    // Bus decode
    logic        setup_phase;
    logic        wr_access;
    logic [11:0] reg_index;
    logic        word_aligned;
    logic        hit_pointer;
    logic        hit_length;
    logic        hit_dma;
    logic        hit_in_en;
    logic        hit_out_en;
    logic        hit_short;
    logic        mapped;
    logic [31:0] rdata_d;

    // Event qualifiers
    logic        reply_step;
    logic        short_left;
    logic        auto_arm_set;
    logic        arm_clear;

    // Address split: index is the word address, low bits must be zero
    always_comb begin
        reg_index    = i_paddr[13:2];
        word_aligned = (i_paddr[1:0] == 2'b00);
        hit_pointer  = word_aligned && (reg_index == UED_IDX_REPLY_POINTER);
        hit_length   = word_aligned && (reg_index == UED_IDX_REPLY_LENGTH);
        hit_dma      = word_aligned && (reg_index == UED_IDX_DMA_FIFO_CTRL);
        hit_in_en    = word_aligned && (reg_index == UED_IDX_IN_ENABLES);
        hit_out_en   = word_aligned && (reg_index == UED_IDX_OUT_ENABLES);
        hit_short    = word_aligned && (reg_index == UED_IDX_SHORT_CTRL);
        mapped       = hit_pointer || hit_length || hit_dma
                    || hit_in_en || hit_out_en || hit_short;
    end

    // Writes take effect in the access phase; no wait states
    assign setup_phase = i_psel && !i_penable;
    assign wr_access   = i_psel && i_penable && i_pwrite;
    assign o_pready    = i_psel && i_penable;
    assign o_prdata    = rdata_q;
    assign o_pslverr   = slverr_q && i_psel && i_penable;

    // Read mux; reserved bits come back as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_pointer) begin
            rdata_d[UED_PTR_W-1:0] = reply_pointer_q;
        end
        if (hit_length) begin
            rdata_d[UED_LEN_W-1:0] = reply_length_q;
        end
        if (hit_dma) begin
            rdata_d[UED_FIFO_RUN_BIT]   = fifo_running_q;
            rdata_d[UED_AUTO_SHORT_BIT] = auto_short_arm_q;
        end
        if (hit_in_en) begin
            rdata_d[UED_EP_NUM-1:0] = in_enable_q;
        end
        if (hit_out_en) begin
            rdata_d[UED_EP_NUM-1:0] = out_enable_q;
        end
        if (hit_short) begin
            rdata_d[UED_SHORT_ARM_BIT] = short_packet_arm_q;
        end
    end

    // Read data and error are captured in the setup cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q  <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (setup_phase) begin
            rdata_q  <= i_pwrite ? 32'h0000_0000 : rdata_d;
            slverr_q <= !mapped;
        end
    end

    // A finished endpoint 0 IN transaction during a descriptor reply
    assign reply_step = i_reply_active && i_ep0_in_done;

    // Reply length: software load, else countdown that stops at zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            reply_length_q <= UED_LEN_RESET;
        end else if (wr_access && hit_length) begin
            reply_length_q <= i_pwdata[UED_LEN_W-1:0];
        end else if (reply_step) begin
            if (i_ep0_in_bytes >= reply_length_q) begin
                reply_length_q <= UED_LEN_RESET;
            end else begin
                reply_length_q <= reply_length_q - i_ep0_in_bytes;
            end
        end
    end

    // Reply read pointer moves forward by the same byte count
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            reply_pointer_q <= UED_PTR_RESET;
        end else if (wr_access && hit_pointer) begin
            reply_pointer_q <= i_pwdata[UED_PTR_W-1:0];
        end else if (reply_step) begin
            reply_pointer_q <= reply_pointer_q
                             + {{(UED_PTR_W-UED_LEN_W){1'b0}}, i_ep0_in_bytes};
        end
    end

    assign o_reply_length_count  = reply_length_q;
    assign o_reply_start_pointer = reply_pointer_q;

    // FIFO running: set at DMA start, dropped once ended and drained
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            fifo_running_q <= 1'b0;
            dma_ended_q    <= 1'b0;
        end else if (i_dma_start) begin
            fifo_running_q <= 1'b1;
            dma_ended_q    <= 1'b0;
        end else if (i_dma_end) begin
            dma_ended_q    <= 1'b1;
            if (i_fifo_empty) begin
                fifo_running_q <= 1'b0;
            end
        end else if (dma_ended_q && i_fifo_empty) begin
            fifo_running_q <= 1'b0;
            dma_ended_q    <= 1'b0;
        end
    end

    assign o_fifo_running = fifo_running_q;

    // Auto arm option; only bit 6 of the DMA control word is writable
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            auto_short_arm_q <= 1'b0;
        end else if (wr_access && hit_dma) begin
            auto_short_arm_q <= i_pwdata[UED_AUTO_SHORT_BIT];
        end
    end

    // Leftover below one max packet at DMA end, on an IN endpoint only
    assign short_left   = ({{(32-FIFO_CNT_W){1'b0}}, i_fifo_count}
                         < {{(32-MPS_W){1'b0}}, i_max_packet});
    assign auto_arm_set = auto_short_arm_q && i_dma_end && short_left
                        && i_dma_ep_is_in;
    assign arm_clear    = i_in_done && i_in_short_sent;

    // Short packet arm: a set in the same cycle as a clear wins
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            short_packet_arm_q <= 1'b0;
        end else if (auto_arm_set) begin
            short_packet_arm_q <= 1'b1;
        end else if (wr_access && hit_short && i_pwdata[UED_SHORT_ARM_BIT]) begin
            short_packet_arm_q <= 1'b1;
        end else if (arm_clear) begin
            short_packet_arm_q <= 1'b0;
        end else if (wr_access && hit_short) begin
            short_packet_arm_q <= 1'b0;
        end
    end

    assign o_short_packet_arm = short_packet_arm_q;

    // IN enable mask; bit 0 never stores
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            in_enable_q <= UED_EN_RESET;
        end else if (wr_access && hit_in_en) begin
            in_enable_q <= i_pwdata[UED_EP_NUM-1:0] & UED_EN_WMASK;
        end
    end

    // OUT enable mask; bit 0 never stores
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            out_enable_q <= UED_EN_RESET;
        end else if (wr_access && hit_out_en) begin
            out_enable_q <= i_pwdata[UED_EP_NUM-1:0] & UED_EN_WMASK;
        end
    end

    // Default replies for enabled but unconfigured endpoints
    ued_token_reply u_token_reply (
        .i_clk                 (i_clk),
        .i_rst                 (i_rst),
        .i_token_valid         (i_token_valid),
        .i_token_kind          (i_token_kind),
        .i_token_ep            (i_token_ep),
        .i_high_speed          (i_high_speed),
        .i_in_enable           (in_enable_q),
        .i_out_enable          (out_enable_q),
        .i_in_iso_null_reply   (i_in_iso_null_reply),
        .i_out_iso_silent_drop (i_out_iso_silent_drop),
        .i_endpoint_area_link  (i_endpoint_area_link),
        .o_reply_valid         (o_reply_valid),
        .o_reply_kind          (o_reply_kind)
    );

endmodule : ued_endpoint_support

`default_nettype wire

// File: dv/ued_es_asserts.sv
/* Concurrent checks on the endpoint support block's ports.
   Assumes a bind onto ued_endpoint_support and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module ued_es_asserts
    import ued_pkg::*;
(
    input wire logic                  i_clk,
    input wire logic                  i_rst,
    input wire logic                  i_psel,
    input wire logic                  i_penable,
    input wire logic                  i_pwrite,
    input wire logic                  i_reply_active,
    input wire logic                  i_ep0_in_done,
    input wire logic [UED_LEN_W-1:0]  i_ep0_in_bytes,
    input wire logic [UED_LEN_W-1:0]  o_reply_length_count,
    input wire logic [UED_PTR_W-1:0]  o_reply_start_pointer,
    input wire logic                  i_dma_start,
    input wire logic                  i_dma_end,
    input wire logic                  i_dma_ep_is_in,
    input wire logic                  i_fifo_empty,
    input wire logic                  o_fifo_running,
    input wire logic                  i_in_done,
    input wire logic                  i_in_short_sent,
    input wire logic                  o_short_packet_arm,
    input wire logic                  i_token_valid,
    input wire ued_token_type         i_token_kind,
    input wire logic [3:0]            i_token_ep,
    input wire logic                  i_high_speed,
    input wire logic [UED_EP_NUM-1:0] i_endpoint_area_link,
    input wire logic                  o_reply_valid,
    input wire ued_reply_type         o_reply_kind
);
    // Write access, auto-arm cause, addressed link bit, full-speed ping
    logic wr_acc;
    logic auto_ev;
    logic link_bit;
    logic ping_fs;
    assign wr_acc   = i_psel & i_penable & i_pwrite;
    assign auto_ev  = i_dma_end & i_dma_ep_is_in;
    assign link_bit = i_endpoint_area_link[i_token_ep];
    assign ping_fs  = i_token_valid & (i_token_kind == UED_TOK_PING) & ~i_high_speed;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // A countdown step that no register write overrides
    sequence s_step;
        i_reply_active && i_ep0_in_done && !wr_acc;
    endsequence
    sequence s_idle;
        !i_reply_active && !wr_acc;
    endsequence

    a_len_step: assert property (s_step |=> o_reply_length_count ==
        (($past(o_reply_length_count) >= $past(i_ep0_in_bytes)) ?
        $past(o_reply_length_count) - $past(i_ep0_in_bytes) : 10'h000))
        else $error("reply length step wrong");
    a_ptr_step: assert property (s_step |=> o_reply_start_pointer ==
        $past(o_reply_start_pointer) + 13'($past(i_ep0_in_bytes)))
        else $error("reply pointer step wrong");
    a_len_hold: assert property (s_idle |=> $stable(o_reply_length_count))
        else $error("reply length moved while idle");
    a_run_set: assert property (i_dma_start |=> o_fifo_running)
        else $error("running flag not set on dma start");
    a_run_hold: assert property (o_fifo_running && !i_fifo_empty |=> o_fifo_running)
        else $error("running flag cleared with data left");
    a_arm_cause: assert property (
        $rose(o_short_packet_arm) |-> $past(auto_ev) || $past(wr_acc))
        else $error("short arm set without in-endpoint dma end");
    a_arm_clear: assert property (
        o_short_packet_arm && i_in_done && i_in_short_sent && !i_dma_end && !wr_acc
        |=> !o_short_packet_arm) else $error("short arm not cleared");
    a_reply_cause: assert property (o_reply_valid |-> $past(i_token_valid))
        else $error("reply without token");
    a_link_none: assert property (i_token_valid && link_bit |=> !o_reply_valid)
        else $error("default reply to joined endpoint");
    a_ping_fs: assert property (ping_fs |=> !o_reply_valid)
        else $error("default reply to full speed ping");
endmodule : ued_es_asserts

bind ued_endpoint_support ued_es_asserts i_ued_es_asserts (
    .i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_reply_active, .i_ep0_in_done,
    .i_ep0_in_bytes, .o_reply_length_count, .o_reply_start_pointer, .i_dma_start,
    .i_dma_end, .i_dma_ep_is_in, .i_fifo_empty, .o_fifo_running, .i_in_done,
    .i_in_short_sent, .o_short_packet_arm, .i_token_valid, .i_token_kind, .i_token_ep,
    .i_high_speed, .i_endpoint_area_link, .o_reply_valid, .o_reply_kind);
`default_nettype wire

// File: dv/ued_host_model.sv
/* Host side model: issues IN, OUT and PING tokens one cycle wide.
   Assumes the bench calls send and shares the block clock. */
`timescale 1ns/1ps
`default_nettype none
module ued_host_model
    import ued_pkg::*;
(
    input  wire logic    i_clk,
    output logic         o_token_valid,
    output ued_token_type o_token_kind,
    output logic [3:0]   o_token_ep
);
    initial begin
        o_token_valid = 1'b0;
        o_token_kind  = UED_TOK_IN;
        o_token_ep    = 4'h0;
    end

    // One token strobe; the endpoint field is scrambled once released
    task automatic send(input ued_token_type k, input logic [3:0] e);
        @(posedge i_clk);
        o_token_valid <= 1'b1;
        o_token_kind  <= k;
        o_token_ep    <= e;
        @(posedge i_clk);
        o_token_valid <= 1'b0;
        o_token_ep    <= ~e;
    endtask : send
endmodule : ued_host_model
`default_nettype wire

// File: dv/ued_endpoint_support_test.sv
/* Self-checking bench for the endpoint support block.
   Assumes the host model and the bound checker sit beside the design. */
`timescale 1ns/1ps
`default_nettype none
module ued_endpoint_support_test;
    import ued_pkg::*;
    logic i_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [13:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0, o_prdata, w;
    logic o_pready, o_pslverr, i_reply_active = 0;
    logic [9:0] i_ep0_in_bytes = '0, o_reply_length_count, len, b;
    logic [12:0] o_reply_start_pointer, ptr, i_fifo_count = '0;
    logic i_dma_ep_is_in = 0, i_fifo_empty = 1;
    logic [10:0] i_max_packet = 11'h040;
    logic [4:0] pv = '0;
    logic tok_v, i_high_speed = 0, hs, o_reply_valid, o_fifo_running, o_short_packet_arm;
    logic [3:0] tok_ep, e;
    logic [15:0] i_in_iso_null_reply = '0, i_out_iso_silent_drop = '0;
    logic [15:0] i_endpoint_area_link = '0, iso_i, iso_o, lnk, in_en, out_en;
    ued_token_type tok_k, k;
    ued_reply_type o_reply_kind, r;
    ued_reply_type rep_q[$];
    logic [32:0] rd_q[$];
    integer seed = 32'h3acfefd9;
    int errors = 0, n_tests = 0, cyc = 0;

    ued_endpoint_support i_ued_endpoint_support (.i_clk, .i_rst, .i_psel, .i_penable,
        .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_reply_active,
        .i_ep0_in_done(pv[0]), .i_ep0_in_bytes, .o_reply_length_count, .o_reply_start_pointer,
        .i_dma_start(pv[1]), .i_dma_end(pv[2]), .i_dma_ep_is_in, .i_fifo_empty, .i_fifo_count,
        .i_max_packet, .i_in_done(pv[3]), .i_in_short_sent(pv[4]), .o_fifo_running,
        .i_token_valid(tok_v), .i_token_kind(tok_k), .i_token_ep(tok_ep), .i_high_speed,
        .i_in_iso_null_reply, .i_out_iso_silent_drop, .i_endpoint_area_link, .o_short_packet_arm,
        .o_reply_valid, .o_reply_kind);
    ued_host_model i_ued_host_model (.i_clk, .o_token_valid(tok_v), .o_token_kind(tok_k),
        .o_token_ep(tok_ep));

    always #20 i_clk = ~i_clk;

    task automatic end_sim;
        $display("Counts: %0d checks, %0d mismatches", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    task automatic chk_val(input string nm, input logic [32:0] x, input logic [32:0] g);
        n_tests++;
        if (g !== x) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, x, g);
        end
    endtask : chk_val

    task automatic chk_rep(input ued_reply_type x, input ued_reply_type g);
        chk_val("reply kind", 33'(x), 33'(g));
    endtask : chk_rep

    // One APB transfer held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= {idx, 2'b00};
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] idx, input logic [32:0] x);
        rd_q.push_back(x);
        apb(1'b0, idx, 32'h0);
    endtask : rd

    task automatic pulse(input logic [4:0] m);
        @(posedge i_clk);
        pv <= m;
        @(posedge i_clk);
        pv <= 5'h00;
        @(posedge i_clk);
    endtask : pulse

    function automatic ued_reply_type exp_rep(input ued_token_type t, input logic [3:0] n);
        if (lnk[n]) return UED_REP_NONE;
        if (t == UED_TOK_IN) return in_en[n] ? (iso_i[n] ? UED_REP_ZLP : UED_REP_NAK) : UED_REP_NONE;
        if (t == UED_TOK_OUT) return out_en[n] ? (iso_o[n] ? UED_REP_DROP : UED_REP_NAK) : UED_REP_NONE;
        return (out_en[n] && hs) ? UED_REP_NAK : UED_REP_NONE;
    endfunction : exp_rep

    // Read data and reply monitors take the oldest note off their queues
    always @(posedge i_clk) begin
        cyc++;
        if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1)
            chk_val("read word", rd_q.pop_front(), {o_pslverr, o_prdata});
        if (o_reply_valid === 1'b1)
            chk_rep(rep_q.size() ? rep_q.pop_front() : UED_REP_NONE, o_reply_kind);
        if (cyc == 6000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(UED_IDX_REPLY_LENGTH, 33'h0);
        rd(UED_IDX_IN_ENABLES, 33'h0);
        rd(UED_IDX_OUT_ENABLES, 33'h0);
        rd(12'h13f, {1'b1, 32'h0});
        apb(1'b1, UED_IDX_REPLY_LENGTH, 32'hffffffff);
        rd(UED_IDX_REPLY_LENGTH, 33'h3ff);
        $display("registers done");
        apb(1'b1, UED_IDX_REPLY_POINTER, 32'h30);
        len = 10'h3ff;
        ptr = 13'h030;
        i_reply_active <= 1'b1;
        for (int i = 0; i < 22; i++) begin
            b = 10'($unsigned($random(seed)) % 97);
            i_ep0_in_bytes <= b;
            if (i == 21) i_reply_active <= 1'b0;
            pulse(5'h01);
            if (i < 21) len = (len >= b) ? len - b : 10'h000;
            if (i < 21) ptr = ptr + 13'(b);
            chk_val("length", 33'(len), 33'(o_reply_length_count));
            chk_val("pointer", 33'(ptr), 33'(o_reply_start_pointer));
        end
        rd(UED_IDX_REPLY_POINTER, 33'(ptr));
        $display("descriptor done");
        apb(1'b1, UED_IDX_DMA_FIFO_CTRL, 32'hff);
        rd(UED_IDX_DMA_FIFO_CTRL, 33'h40);
        i_fifo_empty <= 1'b0;
        i_fifo_count <= 13'd63;
        i_dma_ep_is_in <= 1'b1;
        pulse(5'h02);
        rd(UED_IDX_DMA_FIFO_CTRL, 33'hc0);
        pulse(5'h04);
        chk_val("running", 33'h1, 33'(o_fifo_running));
        chk_val("arm", 33'h1, 33'(o_short_packet_arm));
        rd(UED_IDX_SHORT_CTRL, 33'h1);
        i_fifo_empty <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk_val("running", 33'h0, 33'(o_fifo_running));
        pulse(5'h18);
        chk_val("arm", 33'h0, 33'(o_short_packet_arm));
        i_dma_ep_is_in <= 1'b0;
        pulse(5'h06);
        chk_val("arm", 33'h0, 33'(o_short_packet_arm));
        i_dma_ep_is_in <= 1'b1;
        i_fifo_count <= 13'd64;
        pulse(5'h06);
        chk_val("arm", 33'h0, 33'(o_short_packet_arm));
        $display("dma done");
        for (int i = 0; i < 60; i++) begin
            if (i % 20 == 0) begin
                w = $random(seed);
                apb(1'b1, UED_IDX_IN_ENABLES, w);
                in_en = w[15:0] & UED_EN_WMASK;
                apb(1'b1, UED_IDX_OUT_ENABLES, ~w);
                out_en = ~w[15:0] & UED_EN_WMASK;
            end
            k = (i % 3 == 0) ? UED_TOK_IN : ((i % 3 == 1) ? UED_TOK_OUT : UED_TOK_PING);
            e = 4'($random(seed));
            iso_i = 16'($random(seed));
            iso_o = 16'($random(seed));
            lnk = 16'($random(seed) & $random(seed));
            hs = 1'($random(seed));
            i_in_iso_null_reply <= iso_i;
            i_out_iso_silent_drop <= iso_o;
            i_endpoint_area_link <= lnk;
            i_high_speed <= hs;
            r = exp_rep(k, e);
            if (r != UED_REP_NONE) rep_q.push_back(r);
            i_ued_host_model.send(k, e);
        end
        repeat (3) @(posedge i_clk);
        chk_val("replies left", 33'h0, 33'(rep_q.size()));
        $display("tokens done");
        end_sim();
    end
endmodule : ued_endpoint_support_test
`default_nettype wire
